// ===== verilog/epi_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef EPI_DEFS_SVH
`define EPI_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define EPI_OFF_CTRL      8'h00
`define EPI_OFF_STATUS    8'h01
`define EPI_OFF_NMICFG    8'h02
`define EPI_OFF_NMI_FLAG_REG   8'h03
`define EPI_OFF_EVOUT     8'h04
`define EPI_OFF_IRQENCLR  8'h08
`define EPI_OFF_IRQENSET  8'h09
`define EPI_OFF_IRQFLAG   8'h0A
`define EPI_OFF_WAKE      8'h0B
`define EPI_OFF_CFG0      8'h0C
`define EPI_OFF_CFG1      8'h0D
`define EPI_OFF_CFG2      8'h0E
`define EPI_OFF_CFG3      8'h0F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EPI_CTRL_SOFT_RESET_BIT_BIT   0
`define EPI_CTRL_ENABLE_BIT  1
`define EPI_STATUS_SYNC_BIT  7
`define EPI_NMI_FILT_BIT     3
`define EPI_CFG_FIELD_W      4

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define EPI_RST_BYTE      8'h00
`define EPI_RST_NMICFG    4'h0
`define EPI_RST_CFG       32'h0000_0000
`define EPI_SYNC_CYCLES   3
`define EPI_PIN_COUNT     8

`endif

// ===== verilog/epi_pkg.sv
// types shared by the pin interrupt block and its detectors
package epi_pkg;

	// detector sense selection, one code per trigger condition
	typedef enum logic [2:0]
	{
		EPI_SENSE_NONE = 3'b000,
		EPI_SENSE_RISE = 3'b001,
		EPI_SENSE_FALL = 3'b010,
		EPI_SENSE_BOTH = 3'b011,
		EPI_SENSE_HIGH = 3'b100,
		EPI_SENSE_LOW  = 3'b101
	} epi_sense_e;

endpackage

// ===== verilog/epi_det_if.sv
// interface between the controller and one pin detector
`timescale 1ns/1ps
`default_nettype none

interface epi_det_if;
	import epi_pkg::*;

	epi_sense_e sense;     // selected trigger condition
	logic       filt_en;   // majority filter on
	logic       pin;       // raw pin level, asynchronous
	logic       det_hit;   // condition met this cycle
	logic       det_edge;  // detector is in an edge mode

	modport det (input sense, input filt_en, input pin,
		output det_hit, output det_edge);
	modport ctl (output sense, output filt_en, output pin,
		input det_hit, input det_edge);
endinterface

`default_nettype wire

// ===== verilog/epi_detector.sv
// one pin detector: synchroniser, majority filter and sense logic
`timescale 1ns/1ps
`default_nettype none

module epi_detector
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	epi_det_if.det   det
);
	import epi_pkg::*;

	logic       pin_meta_reg;
	logic       pin_sync_reg;
	logic [2:0] samp_reg;
	logic       lvl_prev_reg;
	logic       lvl_w;
	logic       maj_w;

	// ----------------------------------------------------------------
	// synchroniser and sample history
	// ----------------------------------------------------------------
	// two stages before any logic looks at the pin
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
		end
		else
		begin
			pin_meta_reg <= det.pin;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// three successive samples feed the vote
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			samp_reg <= 3'h0;
		else
			samp_reg <= {samp_reg[1:0], pin_sync_reg};
	end

	// two of three wins; a single-cycle spike is voted away
	assign maj_w = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & samp_reg[2])
		| (samp_reg[1] & samp_reg[2]);
	assign lvl_w = det.filt_en ? maj_w : pin_sync_reg;

	// previous level for edge detection
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			lvl_prev_reg <= 1'b0;
		else
			lvl_prev_reg <= lvl_w;
	end

	// ----------------------------------------------------------------
	// sense decode
	// ----------------------------------------------------------------
	always_comb
	begin
		case (det.sense)
			EPI_SENSE_RISE: det.det_hit = lvl_w & ~lvl_prev_reg;
			EPI_SENSE_FALL: det.det_hit = ~lvl_w & lvl_prev_reg;
			EPI_SENSE_BOTH: det.det_hit = lvl_w ^ lvl_prev_reg;
			EPI_SENSE_HIGH: det.det_hit = lvl_w;
			EPI_SENSE_LOW:  det.det_hit = ~lvl_w;
			default:        det.det_hit = 1'b0;
		endcase
	end

	assign det.det_edge = (det.sense == EPI_SENSE_RISE)
		| (det.sense == EPI_SENSE_FALL) | (det.sense == EPI_SENSE_BOTH);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// checks the vote against the synchronised pin history, so a broken
	// shift chain is caught as well as a broken vote
	filter_vote_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(det.filt_en && !$past(i_rst) && !$past(i_rst, 2)
			&& !$past(i_rst, 3))
		|-> (lvl_w == (($past(pin_sync_reg) + $past(pin_sync_reg, 2)
			+ $past(pin_sync_reg, 3)) >= 2'd2)))
		else $error("majority vote output wrong");

endmodule // epi_detector

`default_nettype wire

// ===== verilog/epi_pin_interrupt_block.sv
// pin interrupt block: register port, flags, requests and events
//
// The address-and-strobe port and the register addresses were decided locally.
`include "epi_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module epi_pin_interrupt_block
#(
	parameter int unsigned SYNC_CYCLES = `EPI_SYNC_CYCLES,
	parameter int unsigned PIN_COUNT   = `EPI_PIN_COUNT
)
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	input  wire logic [7:0]           i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_wr_stb,
	input  wire logic                 i_rd_stb,
	input  wire logic                 i_wr_protect,
	input  wire logic                 i_debug_access,
	input  wire logic                 i_sleep,
	input  wire logic [PIN_COUNT-1:0] i_ext_irq_pin,
	input  wire logic                 i_nmi_pin,
	output logic      [7:0]           o_rdata,
	output logic                      o_irq_req,
	output logic                      o_nmi_req,
	output logic      [PIN_COUNT-1:0] o_event,
	output logic                      o_wake
);
	import epi_pkg::*;

	localparam logic [3:0] SYNC_LOAD = 4'(SYNC_CYCLES - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic                 enable_reg;
	logic                 sync_pending_reg;
	logic [3:0]           sync_cnt_reg;
	logic                 sync_en_reg;
	logic                 sync_rst_reg;
	logic                 q_valid_reg;
	logic                 q_en_reg;
	logic                 q_rst_reg;
	logic [3:0]           nmi_control_reg;
	logic                 nmi_flag_reg;
	logic [PIN_COUNT-1:0] event_out_control_reg;
	logic [PIN_COUNT-1:0] wake_enable_reg;
	logic [PIN_COUNT-1:0] irq_en_reg;
	logic [PIN_COUNT-1:0] irq_flag_reg;
	logic [31:0]          sense_filter_config_reg;
	logic [PIN_COUNT-1:0] hit_prev_reg;
	logic [7:0]           rdata_reg;
	logic                 irq_req_reg;
	logic                 nmi_req_reg;
	logic [PIN_COUNT-1:0] event_reg;
	logic                 wake_reg;

	logic [PIN_COUNT:0]   hit_w;
	logic [PIN_COUNT:0]   edge_w;
	logic [PIN_COUNT-1:0] ext_set_w;
	logic [PIN_COUNT-1:0] irq_active_w;
	logic                 prot_ok_w;
	logic                 sync_done_w;
	logic                 sw_apply_w;
	logic                 clr_w;
	logic                 ctrl_wr_w;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// a write to one offset; protected writes need the guard lifted
	function automatic logic wr_at(input logic [7:0] off,
		input logic guarded);
		wr_at = i_wr_stb && (i_addr == off) && (!guarded || prot_ok_w);
	endfunction

	// protection is lifted for debugger accesses
	assign prot_ok_w = !i_wr_protect || i_debug_access;
	assign ctrl_wr_w = wr_at(`EPI_OFF_CTRL, 1'b1);

	// soft reset takes effect only once its write has synchronised
	assign sync_done_w = sync_pending_reg && (sync_cnt_reg == 4'h0);
	assign sw_apply_w  = sync_done_w && sync_rst_reg;
	assign clr_w       = i_rst || sw_apply_w;

	// ----------------------------------------------------------------
	// detectors, one per pin plus the non-maskable pin
	// ----------------------------------------------------------------
	// detectors run regardless of debug halt or sleep
	epi_det_if u_if[PIN_COUNT+1] ();

	genvar g;
	generate
		for (g = 0; g <= PIN_COUNT; g++)
		begin : g_det
			if (g < PIN_COUNT)
			begin : g_ext
				assign u_if[g].sense   = epi_sense_e'(
					sense_filter_config_reg[g*`EPI_CFG_FIELD_W +: 3]);
				assign u_if[g].filt_en = sense_filter_config_reg[
					g*`EPI_CFG_FIELD_W + `EPI_NMI_FILT_BIT];
				assign u_if[g].pin     = i_ext_irq_pin[g];
			end
			else
			begin : g_nmi
				assign u_if[g].sense   = epi_sense_e'(nmi_control_reg[2:0]);
				assign u_if[g].filt_en = nmi_control_reg[`EPI_NMI_FILT_BIT];
				assign u_if[g].pin     = i_nmi_pin;
			end
			epi_detector u_det
			(
				.i_core_clk (i_core_clk),
				.i_rst      (clr_w),
				.det        (u_if[g])
			);
			assign hit_w[g]  = u_if[g].det_hit;
			assign edge_w[g] = u_if[g].det_edge;
		end
	endgenerate

	// external pin flags only set while the controller is enabled
	assign ext_set_w = hit_w[PIN_COUNT-1:0] & {PIN_COUNT{enable_reg}};

	// ----------------------------------------------------------------
	// control synchronisation
	// ----------------------------------------------------------------
	// the slave never stalls, so a write made while busy is parked in
	// a one-deep queue and started when the current one completes
	always_ff @(posedge i_core_clk)
	begin
		if (clr_w)
		begin
			enable_reg       <= 1'b0;
			sync_pending_reg <= 1'b0;
			sync_cnt_reg     <= 4'h0;
			sync_en_reg      <= 1'b0;
			sync_rst_reg     <= 1'b0;
			q_valid_reg      <= 1'b0;
			q_en_reg         <= 1'b0;
			q_rst_reg        <= 1'b0;
		end
		else
		begin
			if (sync_pending_reg && !sync_done_w)
				sync_cnt_reg <= sync_cnt_reg - 4'h1;
			if (sync_done_w)
			begin
				enable_reg <= sync_en_reg;
				if (q_valid_reg)
				begin
					sync_en_reg  <= q_en_reg;
					sync_rst_reg <= q_rst_reg;
					sync_cnt_reg <= SYNC_LOAD;
					q_valid_reg  <= 1'b0;
				end
				else
					sync_pending_reg <= 1'b0;
			end
			if (ctrl_wr_w)
			begin
				if (!sync_pending_reg || (sync_done_w && !q_valid_reg))
				begin
					sync_pending_reg <= 1'b1;
					sync_cnt_reg     <= SYNC_LOAD;
					sync_en_reg      <= i_wdata[`EPI_CTRL_ENABLE_BIT];
					sync_rst_reg     <= i_wdata[`EPI_CTRL_SOFT_RESET_BIT_BIT];
				end
				else
				begin
					q_valid_reg <= 1'b1;
					q_en_reg    <= i_wdata[`EPI_CTRL_ENABLE_BIT];
					q_rst_reg   <= i_wdata[`EPI_CTRL_SOFT_RESET_BIT_BIT];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// all guarded by write protection
	always_ff @(posedge i_core_clk)
	begin
		if (clr_w)
		begin
			nmi_control_reg         <= `EPI_RST_NMICFG;
			event_out_control_reg   <= `EPI_RST_BYTE;
			wake_enable_reg         <= `EPI_RST_BYTE;
			irq_en_reg              <= `EPI_RST_BYTE;
			sense_filter_config_reg <= `EPI_RST_CFG;
		end
		else
		begin
			if (wr_at(`EPI_OFF_NMICFG, 1'b1))
				nmi_control_reg <= i_wdata[3:0];
			if (wr_at(`EPI_OFF_EVOUT, 1'b1))
				event_out_control_reg <= i_wdata;
			if (wr_at(`EPI_OFF_WAKE, 1'b1))
				wake_enable_reg <= i_wdata;
			if (wr_at(`EPI_OFF_IRQENSET, 1'b1))
				irq_en_reg <= irq_en_reg | i_wdata;
			else if (wr_at(`EPI_OFF_IRQENCLR, 1'b1))
				irq_en_reg <= irq_en_reg & ~i_wdata;
			if (wr_at(`EPI_OFF_CFG0, 1'b1))
				sense_filter_config_reg[7:0] <= i_wdata;
			if (wr_at(`EPI_OFF_CFG1, 1'b1))
				sense_filter_config_reg[15:8] <= i_wdata;
			if (wr_at(`EPI_OFF_CFG2, 1'b1))
				sense_filter_config_reg[23:16] <= i_wdata;
			if (wr_at(`EPI_OFF_CFG3, 1'b1))
				sense_filter_config_reg[31:24] <= i_wdata;
		end
	end

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	// write one to clear; a detection in the same cycle wins, and a
	// level that still matches re-sets the flag straight away
	always_ff @(posedge i_core_clk)
	begin
		if (clr_w)
		begin
			irq_flag_reg <= `EPI_RST_BYTE;
			nmi_flag_reg <= 1'b0;
		end
		else
		begin
			if (wr_at(`EPI_OFF_IRQFLAG, 1'b0))
				irq_flag_reg <= (irq_flag_reg & ~i_wdata) | ext_set_w;
			else
				irq_flag_reg <= irq_flag_reg | ext_set_w;
			if (wr_at(`EPI_OFF_NMI_FLAG_REG, 1'b0) && i_wdata[0])
				nmi_flag_reg <= hit_w[PIN_COUNT];
			else
				nmi_flag_reg <= nmi_flag_reg | hit_w[PIN_COUNT];
		end
	end

	// ----------------------------------------------------------------
	// requests, wake and events
	// ----------------------------------------------------------------
	// in sleep only wake-enabled pins may request
	assign irq_active_w = irq_flag_reg & irq_en_reg
		& (i_sleep ? wake_enable_reg : {PIN_COUNT{1'b1}});

	always_ff @(posedge i_core_clk)
	begin
		if (clr_w)
		begin
			irq_req_reg <= 1'b0;
			nmi_req_reg <= 1'b0;
			wake_reg    <= 1'b0;
		end
		else
		begin
			irq_req_reg <= |irq_active_w;
			nmi_req_reg <= nmi_flag_reg;
			wake_reg    <= i_sleep && ((|irq_active_w) || nmi_flag_reg);
		end
	end

	// a level detection yields one pulse at its start only
	always_ff @(posedge i_core_clk)
	begin
		if (clr_w)
		begin
			hit_prev_reg <= `EPI_RST_BYTE;
			event_reg    <= `EPI_RST_BYTE;
		end
		else
		begin
			hit_prev_reg <= ext_set_w;
			event_reg    <= event_out_control_reg & ext_set_w
				& (edge_w[PIN_COUNT-1:0] | ~hit_prev_reg);
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// data valid in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_core_clk)
	begin
		if (clr_w)
			rdata_reg <= `EPI_RST_BYTE;
		else if (i_rd_stb)
		begin
			case (i_addr)
				`EPI_OFF_CTRL:     rdata_reg <= {6'h00, enable_reg,
					sync_pending_reg & sync_rst_reg};
				`EPI_OFF_STATUS:   rdata_reg <= {sync_pending_reg, 7'h00};
				`EPI_OFF_NMICFG:   rdata_reg <= {4'h0, nmi_control_reg};
				`EPI_OFF_NMI_FLAG_REG:  rdata_reg <= {7'h00, nmi_flag_reg};
				`EPI_OFF_EVOUT:    rdata_reg <= event_out_control_reg;
				`EPI_OFF_IRQENCLR: rdata_reg <= irq_en_reg;
				`EPI_OFF_IRQENSET: rdata_reg <= irq_en_reg;
				`EPI_OFF_IRQFLAG:  rdata_reg <= irq_flag_reg;
				`EPI_OFF_WAKE:     rdata_reg <= wake_enable_reg;
				`EPI_OFF_CFG0:     rdata_reg <= sense_filter_config_reg[7:0];
				`EPI_OFF_CFG1:     rdata_reg <= sense_filter_config_reg[15:8];
				`EPI_OFF_CFG2:     rdata_reg <= sense_filter_config_reg[23:16];
				`EPI_OFF_CFG3:     rdata_reg <= sense_filter_config_reg[31:24];
				default:           rdata_reg <= 8'h00;
			endcase
		end
	end

	assign o_rdata   = rdata_reg;
	assign o_irq_req = irq_req_reg;
	assign o_nmi_req = nmi_req_reg;
	assign o_event   = event_reg;
	assign o_wake    = wake_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (clr_w);

	sequence ctrl_start_s;
		ctrl_wr_w && !sync_pending_reg;
	endsequence

	sequence sync_window_s;
		sync_pending_reg [*3] ##1 !sync_pending_reg;
	endsequence

	sync_busy_a: assert property (ctrl_start_s |=> sync_window_s)
		else $error("sync pending did not track a lone control write");
	sync_done_a: assert property ($rose(sync_pending_reg)
		|-> ##[1:8] !sync_pending_reg || q_valid_reg)
		else $error("control synchronisation never completed");
	enable_apply_a: assert property ((sync_done_w && !sync_rst_reg)
		|=> enable_reg == $past(sync_en_reg))
		else $error("enable not applied after sync");
	nmi_follow_a: assert property (nmi_flag_reg |=> o_nmi_req)
		else $error("nmi request missing");
	// a soft reset clears the request register without looking at flags
	irq_gate_a: assert property (!$past(clr_w) |->
		o_irq_req == ($past(irq_active_w) != '0))
		else $error("shared request does not follow enabled flags");
	sleep_mask_a: assert property ((i_sleep &&
		((irq_flag_reg & irq_en_reg & wake_enable_reg) == '0))
		|=> !o_irq_req)
		else $error("masked pin requested during sleep");
	flag_set_wins_a: assert property ((wr_at(`EPI_OFF_IRQFLAG, 1'b0)
		&& i_wdata[1] && ext_set_w[1]) |=> irq_flag_reg[1])
		else $error("flag set lost against clear");
	protect_a: assert property ((i_wr_stb && i_wr_protect
		&& !i_debug_access && i_addr == `EPI_OFF_WAKE)
		|=> $stable(wake_enable_reg))
		else $error("protected write took effect");
	debug_wr_a: assert property ((i_wr_stb && i_wr_protect
		&& i_debug_access && i_addr == `EPI_OFF_WAKE) |=> wake_enable_reg == $past(i_wdata))
		else $error("debugger write blocked");
	level_pulse_a: assert property ((o_event[0] && !$past(edge_w[0]))
		|=> !o_event[0])
		else $error("level event longer than one cycle");
	soft_reset_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		sw_apply_w |=> !enable_reg && irq_en_reg == 8'h00 && !sync_pending_reg)
		else $error("soft reset left state behind");

endmodule // epi_pin_interrupt_block

`default_nettype wire

// ===== tb/epi_pin_partner.sv
// far side model: pin drivers and the cpu request taker
`timescale 1ns/1ps
`default_nettype none

module epi_pin_partner
(
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_pin_lvl,
	input  wire logic       i_nmi_lvl,
	input  wire logic       i_nmi_req,
	input  wire logic [7:0] i_event,
	output logic      [7:0] o_ext_irq_pin,
	output logic            o_nmi_pin,
	output logic      [7:0] o_event_cycles = 8'h00,
	output logic            o_nmi_seen = 1'b0
);
	// pins move mid-cycle, they are not tied to the core clock
	assign #7 o_ext_irq_pin = i_pin_lvl;
	assign #7 o_nmi_pin = i_nmi_lvl;

	// cycles with any event high; one edge must give exactly one
	always @(posedge i_core_clk)
		o_event_cycles <= o_event_cycles + {7'h00, |i_event};

	// cpu side takes the request with no setup of its own
	always @(posedge i_core_clk)
		o_nmi_seen <= o_nmi_seen | i_nmi_req;
endmodule // epi_pin_partner

`default_nettype wire

// ===== tb/epi_pin_interrupt_block_bench.sv
// self-checking bench for the pin interrupt block
`include "epi_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module epi_pin_interrupt_block_bench;
	import epi_pkg::*;

	logic       i_core_clk     = 1'b0;
	logic       i_rst          = 1'b1;
	logic [7:0] i_addr         = 8'h00;
	logic [7:0] i_wdata        = 8'h00;
	logic       i_wr_stb       = 1'b0;
	logic       i_rd_stb       = 1'b0;
	logic       i_wr_protect   = 1'b0;
	logic       i_debug_access = 1'b0;
	logic       i_sleep        = 1'b0;
	logic [7:0] pin_lvl        = 8'h00;
	logic       nmi_lvl        = 1'b0;
	logic [7:0] pins;
	logic       nmi_pin;
	logic [7:0] o_rdata;
	logic       o_irq_req;
	logic       o_nmi_req;
	logic [7:0] o_event;
	logic       o_wake;
	logic [7:0] ev_cyc;
	logic [7:0] ev0;
	logic       nmi_seen;
	int         n_mismatch     = 0;
	int         comparisons    = 0;
	epi_sense_e sc [3]         = '{EPI_SENSE_FALL, EPI_SENSE_BOTH,
		EPI_SENSE_LOW};

	// 25 ns period
	always #12.5 i_core_clk = ~i_core_clk;

	epi_pin_interrupt_block u_epi_pin_interrupt_block
	(
		.i_core_clk     (i_core_clk),
		.i_rst          (i_rst),
		.i_addr         (i_addr),
		.i_wdata        (i_wdata),
		.i_wr_stb       (i_wr_stb),
		.i_rd_stb       (i_rd_stb),
		.i_wr_protect   (i_wr_protect),
		.i_debug_access (i_debug_access),
		.i_sleep        (i_sleep),
		.i_ext_irq_pin  (pins),
		.i_nmi_pin      (nmi_pin),
		.o_rdata        (o_rdata),
		.o_irq_req      (o_irq_req),
		.o_nmi_req      (o_nmi_req),
		.o_event        (o_event),
		.o_wake         (o_wake)
	);

	epi_pin_partner u_epi_pin_partner
	(
		.i_core_clk     (i_core_clk),
		.i_pin_lvl      (pin_lvl),
		.i_nmi_lvl      (nmi_lvl),
		.i_nmi_req      (o_nmi_req),
		.i_event        (o_event),
		.o_ext_irq_pin  (pins),
		.o_nmi_pin      (nmi_pin),
		.o_event_cycles (ev_cyc),
		.o_nmi_seen     (nmi_seen)
	);

	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr   <= a;
		i_wdata  <= d;
		i_wr_stb <= 1'b1;
		@(posedge i_core_clk);
		i_wr_stb <= 1'b0;
	endtask

	// read data appears in the cycle after the strobe and holds until the next read
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		i_addr   <= a;
		i_rd_stb <= 1'b1;
		@(posedge i_core_clk);
		i_rd_stb <= 1'b0;
		#1 chk($sformatf("reg %h", a), o_rdata, e);
	endtask

	// bounded wait, the detector path is a few cycles long
	task automatic wait_irq();
		int n;
		n = 0;
		while (o_irq_req !== 1'b1 && n < 20)
		begin
			@(posedge i_core_clk);
			#1 n++;
		end
		chk("irq", {7'h00, o_irq_req}, 8'h01);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog, the tests need well under a thousand cycles
	initial
	begin
		#(25 * 5000);
		n_mismatch++;
		print_verdict();
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		idle(16);
		i_rst <= 1'b0;
		rdchk(`EPI_OFF_CTRL, 8'h00);
		rdchk(`EPI_OFF_IRQENSET, 8'h00);
		rdchk(8'h20, 8'h00);
		// configuration before enable, pin1 high level
		wr(`EPI_OFF_EVOUT, 8'h01);
		wr(`EPI_OFF_WAKE, 8'h02);
		wr(`EPI_OFF_CFG0, 8'h41);
		wr(`EPI_OFF_IRQENSET, 8'h03);
		wr(`EPI_OFF_CTRL, 8'h02);
		rdchk(`EPI_OFF_STATUS, 8'h80);
		idle(6);
		rdchk(`EPI_OFF_STATUS, 8'h00);
		rdchk(`EPI_OFF_CTRL, 8'h02);
		// pin0 rising edge, event pulse, no re-set after clear
		ev0 = ev_cyc;
		@(posedge i_core_clk);
		pin_lvl[0] <= 1'b1;
		wait_irq();
		idle(2);
		chk("events", ev_cyc - ev0, 8'h01);
		wr(`EPI_OFF_IRQFLAG, 8'h01);
		idle(6);
		#1 chk("irq", {7'h00, o_irq_req}, 8'h00);
		// remaining sense codes, each triggered by a low-going pin
		for (int k = 0; k < 3; k++)
		begin
			wr(`EPI_OFF_CFG0, {4'h4, 1'b0, sc[k]});
			pin_lvl[0] <= 1'b1;
			idle(8);
			wr(`EPI_OFF_IRQFLAG, 8'h01);
			pin_lvl[0] <= 1'b0;
			idle(8);
			rdchk(`EPI_OFF_IRQFLAG, 8'h01);
		end
		wr(`EPI_OFF_CFG0, 8'h40);
		wr(`EPI_OFF_IRQFLAG, 8'h01);
		rdchk(`EPI_OFF_IRQFLAG, 8'h00);
		// level flag sets again at once while the pin matches
		@(posedge i_core_clk);
		pin_lvl[1] <= 1'b1;
		wait_irq();
		wr(`EPI_OFF_IRQFLAG, 8'h02);
		idle(2);
		rdchk(`EPI_OFF_IRQFLAG, 8'h02);
		wr(`EPI_OFF_IRQENCLR, 8'h02);
		idle(2);
		#1 chk("irq", {7'h00, o_irq_req}, 8'h00);
		rdchk(`EPI_OFF_IRQENSET, 8'h01);
		// sleep: only wake-enabled pins pass
		wr(`EPI_OFF_IRQENSET, 8'h02);
		i_sleep <= 1'b1;
		idle(3);
		#1 chk("wake", {7'h00, o_wake}, 8'h01);
		wr(`EPI_OFF_WAKE, 8'h00);
		idle(2);
		#1 chk("wake", {7'h00, o_wake}, 8'h00);
		chk("irq", {7'h00, o_irq_req}, 8'h00);
		@(posedge i_core_clk);
		i_sleep <= 1'b0;
		pin_lvl[1] <= 1'b0;
		i_wr_protect <= 1'b1;
		idle(6);
		// protection spares the flag registers only (pin flags and nmi flag)
		wr(`EPI_OFF_IRQFLAG, 8'h02);
		wr(`EPI_OFF_WAKE, 8'hFF);
		rdchk(`EPI_OFF_IRQFLAG, 8'h00);
		rdchk(`EPI_OFF_WAKE, 8'h00);
		@(posedge i_core_clk);
		i_debug_access <= 1'b1;
		wr(`EPI_OFF_WAKE, 8'hFF);
		rdchk(`EPI_OFF_WAKE, 8'hFF);
		@(posedge i_core_clk);
		i_wr_protect <= 1'b0;
		i_debug_access <= 1'b0;
		// a one-cycle spike loses the vote, a held level wins
		wr(`EPI_OFF_CFG1, 8'h0C);
		pin_lvl[2] <= 1'b1;
		@(posedge i_core_clk);
		pin_lvl[2] <= 1'b0;
		idle(10);
		rdchk(`EPI_OFF_IRQFLAG, 8'h00);
		@(posedge i_core_clk);
		pin_lvl[2] <= 1'b1;
		idle(12);
		rdchk(`EPI_OFF_IRQFLAG, 8'h04);
		// soft reset clears everything and disables
		wr(`EPI_OFF_CTRL, 8'h01);
		idle(6);
		rdchk(`EPI_OFF_CTRL, 8'h00);
		rdchk(`EPI_OFF_WAKE, 8'h00);
		rdchk(`EPI_OFF_IRQFLAG, 8'h00);
		// non-maskable pin works while the block is disabled
		wr(`EPI_OFF_NMICFG, 8'h01);
		nmi_lvl <= 1'b1;
		idle(8);
		#1 chk("nmi seen", {7'h00, nmi_seen}, 8'h01);
		chk("irq", {7'h00, o_irq_req}, 8'h00);
		rdchk(`EPI_OFF_NMI_FLAG_REG, 8'h01);
		wr(`EPI_OFF_NMI_FLAG_REG, 8'h01);
		idle(2);
		#1 chk("nmi", {7'h00, o_nmi_req}, 8'h00);
		print_verdict();
	end
endmodule // epi_pin_interrupt_block_bench

`default_nettype wire
